// ### rtl/sysclk_pkg.sv
// Behaviour
// - Sub clock comes from crystal or slow RC, picked by low_clock_select.
// - Crystal output is used only after a start-up delay once enabled.
// - Crystal pins serve shared functions whenever the crystal is unused.
// - Quick-start bit 0 runs crystal in low-power mode, 1 in quick-start.
// - Clearing quick-start after start-up keeps the crystal running unbroken.
// - Crystal mode writes are ignored while crystal drives the system clock.
// - Crystal clocks normally in both modes; low-power only starts slower.
// - Slow RC oscillator is the other sub clock source.
// - System clock is fast clock or sub clock per sysclk_divide_select.
// - Fast clock comes only from the fast RC oscillator.
// - Fast clock divided by 1 up to 64 is offered as system clock.
// - System clock is gated off while the CPU is halted.
// - Timers get a clock independent of the gated system clock.
// - In slow mode fast oscillator runs or stops per its enable bit.
// - Select codes 000..110 give fast divided 1..64, 111 gives sub clock.
// - low_clock_select 0 picks slow RC, 1 picks crystal; resets to 0.
// - Fast RC stable flag clears while it is stopped or restarting, set again once stable.
// - When halted, oscillators keep running only if their keep bit is set.
package sysclk_pkg;
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] ADDR_SCC = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_HIRCC = 12'h004;
    localparam logic [ADDR_W-1:0] ADDR_SLOW_CRYSTAL_CONTROL_REG = 12'h008;
    localparam logic [ADDR_W-1:0] ADDR_PINS = 12'h00C;
    localparam int SCC_DIV_LSB = 5;
    localparam int SCC_FSS_BIT = 2;
    localparam int SCC_FKEEP_BIT = 1;
    localparam int SCC_SKEEP_BIT = 0;
    localparam int HIRCC_FLAG_BIT = 1;
    localparam int HIRCC_EN_BIT = 0;
    localparam int SLOW_CRYSTAL_CONTROL_REG_SP_BIT = 2;
    localparam int SLOW_CRYSTAL_CONTROL_REG_FLAG_BIT = 1;
    localparam int SLOW_CRYSTAL_CONTROL_REG_EN_BIT = 0;
    localparam int PINS_FUNC_LSB = 0;
    localparam logic [2:0] DIV_RST = 3'h0;
    localparam logic [2:0] DIV_SUB = 3'h7;
    localparam logic FSS_RST = 1'b0;
    localparam logic FKEEP_RST = 1'b0;
    localparam logic SKEEP_RST = 1'b0;
    localparam logic FAST_EN_RST = 1'b1;
    localparam logic LXT_EN_RST = 1'b0;
    localparam logic LXT_SP_RST = 1'b0;
    localparam logic [1:0] PINS_RST = 2'h0;
    // Oscillator edges counted before an oscillator is taken as stable
    localparam logic [11:0] FAST_STABLE_EDGES = 12'h010;
    localparam logic [11:0] LXT_QUICK_EDGES = 12'h100;
    localparam logic [11:0] LXT_SLOW_EDGES = 12'h800;
    typedef enum {XT_OFF, XT_START, XT_RUN} xt_state_t;
    typedef struct packed {
        logic fast_rc_run;
        logic slow_rc_run;
        logic crystal_run;
        logic crystal_low_power;
    } osc_ctrl_t;
endpackage

// ### rtl/system_clock_source_select.sv
`timescale 1ns/1ps
module osc_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // osc_sync

module system_clock_source_select (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sysclk_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Raw oscillator outputs
    input wire logic fast_rc_osc,
    input wire logic slow_rc_osc,
    input wire logic crystal_pin_in,
    // CPU state
    input wire logic cpu_halt,
    // Oscillator controls and clock enables
    output sysclk_pkg::osc_ctrl_t osc_ctrl,
    output logic system_clock_en,
    output logic sub_clock_en,
    output logic timer_clock_en,
    output logic [6:0] fast_div_en,
    // Crystal pin sharing
    output logic crystal_pins_to_osc,
    output logic [1:0] crystal_pin_func
);
    import sysclk_pkg::*;

    logic [2:0] raw_sync;
    logic [2:0] raw_prev_q;
    logic [2:0] edge_rise;
    logic [2:0] div_sel_q;
    logic low_clock_select_q;
    logic fast_osc_halt_keep_q;
    logic slow_osc_halt_keep_q;
    logic fast_rc_enable_q;
    logic fast_rc_stable_flag_q;
    logic [11:0] fast_cnt_q;
    logic fast_run_prev_q;
    logic slow_crystal_enable_q;
    logic slow_crystal_quick_start_q;
    xt_state_t xt_state_q;
    xt_state_t xt_state_d;
    logic [11:0] xt_cnt_q;
    logic [1:0] pin_func_q;
    logic [5:0] div_cnt_q;
    logic [2:0] act_sel_q;
    logic act_fss_q;
    logic skip_q;
    logic [31:0] prdata_q;

    // Oscillator edges enter the pclk domain through two flip-flops
    osc_sync #(
        .WIDTH(3)
    ) osc_sync_inst (
        .clk(pclk),
        .rst_n(presetn),
        .async_in({crystal_pin_in, slow_rc_osc, fast_rc_osc}),
        .sync_out(raw_sync)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_prev_q <= 3'h0;
        end else begin
            raw_prev_q <= raw_sync;
        end
    end

    // Rising edges of the synchronised oscillator waveforms
    assign edge_rise = raw_sync & ~raw_prev_q;

    // APB decode
    wire setup_ph = psel && !penable;
    wire access_ph = psel && penable;
    wire hit_scc = (paddr == ADDR_SCC);
    wire hit_hircc = (paddr == ADDR_HIRCC);
    wire hit_slow_crystal_control_reg = (paddr == ADDR_SLOW_CRYSTAL_CONTROL_REG);
    wire hit_pins = (paddr == ADDR_PINS);
    wire hit_any = hit_scc || hit_hircc || hit_slow_crystal_control_reg || hit_pins;
    wire wr_en = access_ph && pwrite && hit_any;
    wire wr_scc = wr_en && hit_scc;
    wire wr_hircc = wr_en && hit_hircc;
    wire wr_slow_crystal_control_reg = wr_en && hit_slow_crystal_control_reg;
    wire wr_pins = wr_en && hit_pins;

    // Zero wait states: every access completes in its first cycle
    assign pready = access_ph;
    assign pslverr = access_ph && !hit_any;
    assign prdata = prdata_q;

    // Oscillator run decisions; halt keep bits decide what survives a halt
    wire fast_in_use = (act_sel_q != DIV_SUB) && !cpu_halt;
    wire fast_halt_ok = !cpu_halt || fast_osc_halt_keep_q;
    wire slow_halt_ok = !cpu_halt || slow_osc_halt_keep_q;
    wire fast_run = (fast_rc_enable_q || fast_in_use) && fast_halt_ok;
    wire slow_rc_run = slow_halt_ok;
    wire xt_run = slow_crystal_enable_q && slow_halt_ok;
    wire xt_ready = (xt_state_q == XT_RUN);
    wire xt_is_sysclk = (act_sel_q == DIV_SUB) && act_fss_q;
    wire [11:0] xt_limit = slow_crystal_quick_start_q ? LXT_QUICK_EDGES :
                                                        LXT_SLOW_EDGES;

    // Fast clock ticks only from the fast RC oscillator once stable
    wire fast_ok = fast_run && fast_rc_stable_flag_q;
    wire fast_tick = edge_rise[0] && fast_ok;
    wire rc_tick = edge_rise[1] && slow_rc_run;
    wire xt_tick = edge_rise[2] && xt_run && xt_ready;
    wire sub_tick = low_clock_select_q ? xt_tick : rc_tick;
    wire act_sub_tick = act_fss_q ? xt_tick : rc_tick;

    // Fast clock divider; outputs run whenever the fast oscillator runs and is stable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_q <= 6'h00;
        end else if (fast_tick) begin
            div_cnt_q <= div_cnt_q + 6'h01;
        end
    end

    assign fast_div_en[0] = fast_tick;
    genvar k;
    generate
        for (k = 1; k < 7; k++) begin : g_div
            assign fast_div_en[k] = fast_tick && (&div_cnt_q[k-1:0]);
        end
    endgenerate

    // Glitch-free selection: a change takes effect on a tick of the old
    // source, or at once if that source has stopped, and the first tick of the new source is swallowed so no
    // period comes out shorter than a full one of either source
    wire [2:0] want_sel = div_sel_q;
    wire sel_pending = (want_sel != act_sel_q) ||
                       ((want_sel == DIV_SUB) &&
                        (low_clock_select_q != act_fss_q));
    wire act_running = (act_sel_q == DIV_SUB) ?
                       (act_fss_q ? (xt_run && xt_ready) : slow_rc_run) :
                       fast_ok;
    wire act_tick = (act_sel_q == DIV_SUB) ? act_sub_tick :
                    fast_div_en[act_sel_q];
    wire do_switch = sel_pending && (act_tick || !act_running);

    // Active selection moves only on a switch; skip_q swallows one tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_sel_q <= DIV_RST;
            act_fss_q <= FSS_RST;
            skip_q <= 1'b0;
        end else if (do_switch) begin
            act_sel_q <= want_sel;
            act_fss_q <= low_clock_select_q;
            skip_q <= 1'b1;
        end else if (act_tick) begin
            skip_q <= 1'b0;
        end
    end

    assign system_clock_en = act_tick && !skip_q && !do_switch &&
                             !cpu_halt;
    assign sub_clock_en = sub_tick;
    // Timers keep the sub clock, which a halt stops unless the slow keep bit is set
    assign timer_clock_en = sub_tick;

    // Fast RC stable flag: cleared while the oscillator is stopped or restarting, set after enough edges
    wire fast_restart = !fast_run || !fast_run_prev_q;
    wire fast_count_step = !fast_rc_stable_flag_q && edge_rise[0];
    wire fast_count_done = (fast_cnt_q == FAST_STABLE_EDGES - 12'h001);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_run_prev_q <= 1'b0;
            fast_cnt_q <= 12'h000;
            fast_rc_stable_flag_q <= 1'b0;
        end else begin
            fast_run_prev_q <= fast_run;
            if (fast_restart) begin
                fast_cnt_q <= 12'h000;
                fast_rc_stable_flag_q <= 1'b0;
            end else if (fast_count_step) begin
                if (fast_count_done) begin
                    fast_rc_stable_flag_q <= 1'b1;
                end else begin
                    fast_cnt_q <= fast_cnt_q + 12'h001;
                end
            end
        end
    end

    // Crystal start-up sequencing
    wire xt_count_done = (xt_cnt_q >= xt_limit - 12'h001);
    wire xt_count_step = (xt_state_q == XT_START) && xt_run &&
                         edge_rise[2] && !xt_count_done;

    always_comb begin
        xt_state_d = xt_state_q;
        case (xt_state_q)
            XT_OFF: begin
                if (xt_run) begin
                    xt_state_d = XT_START;
                end
            end
            XT_START: begin
                if (!xt_run) begin
                    xt_state_d = XT_OFF;
                end else if (edge_rise[2] && xt_count_done) begin
                    xt_state_d = XT_RUN;
                end
            end
            XT_RUN: begin
                // Mode changes here leave the crystal running
                if (!xt_run) begin
                    xt_state_d = XT_OFF;
                end
            end
            default: begin
                xt_state_d = XT_OFF;
            end
        endcase
    end

    // Start-up count is cleared outside the start-up state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xt_state_q <= XT_OFF;
            xt_cnt_q <= 12'h000;
        end else begin
            xt_state_q <= xt_state_d;
            if (xt_state_q != XT_START) begin
                xt_cnt_q <= 12'h000;
            end else if (xt_count_step) begin
                xt_cnt_q <= xt_cnt_q + 12'h001;
            end
        end
    end

    // Fields carried by a register write
    wire [2:0] wr_div_sel = pwdata[SCC_DIV_LSB +: 3];
    wire wr_low_clock_select = pwdata[SCC_FSS_BIT];
    wire wr_fast_keep = pwdata[SCC_FKEEP_BIT];
    wire wr_slow_keep = pwdata[SCC_SKEEP_BIT];
    wire wr_fast_enable = pwdata[HIRCC_EN_BIT];
    wire wr_xt_enable = pwdata[SLOW_CRYSTAL_CONTROL_REG_EN_BIT];
    wire wr_xt_quick = pwdata[SLOW_CRYSTAL_CONTROL_REG_SP_BIT];
    wire [1:0] wr_pin_func = pwdata[PINS_FUNC_LSB +: 2];
    // Quick-start bit is frozen while the crystal drives the system clock
    wire xt_mode_wr = wr_slow_crystal_control_reg && !xt_is_sysclk;

    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_sel_q <= DIV_RST;
            low_clock_select_q <= FSS_RST;
            fast_osc_halt_keep_q <= FKEEP_RST;
            slow_osc_halt_keep_q <= SKEEP_RST;
        end else if (wr_scc) begin
            div_sel_q <= wr_div_sel;
            low_clock_select_q <= wr_low_clock_select;
            fast_osc_halt_keep_q <= wr_fast_keep;
            slow_osc_halt_keep_q <= wr_slow_keep;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_rc_enable_q <= FAST_EN_RST;
        end else if (wr_hircc) begin
            fast_rc_enable_q <= wr_fast_enable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_crystal_enable_q <= LXT_EN_RST;
            slow_crystal_quick_start_q <= LXT_SP_RST;
        end else begin
            if (wr_slow_crystal_control_reg) begin
                slow_crystal_enable_q <= wr_xt_enable;
            end
            if (xt_mode_wr) begin
                slow_crystal_quick_start_q <= wr_xt_quick;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_func_q <= PINS_RST;
        end else if (wr_pins) begin
            pin_func_q <= wr_pin_func;
        end
    end

    // Read data is captured in the setup phase
    wire [31:0] rd_scc = {24'h000000, div_sel_q, 2'h0, low_clock_select_q,
                          fast_osc_halt_keep_q, slow_osc_halt_keep_q};
    wire [31:0] rd_hircc = {30'h0000000, fast_rc_stable_flag_q,
                            fast_rc_enable_q};
    wire [31:0] rd_slow_crystal_control_reg = {29'h0000000, slow_crystal_quick_start_q,
                           xt_ready, slow_crystal_enable_q};
    wire [31:0] rd_pins = {30'h0000000, pin_func_q};
    wire [31:0] rd_data = hit_scc ? rd_scc :
                          hit_hircc ? rd_hircc :
                          hit_slow_crystal_control_reg ? rd_slow_crystal_control_reg :
                          hit_pins ? rd_pins : 32'h00000000;
    wire rd_capture = setup_ph && !pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else if (rd_capture) begin
            prdata_q <= rd_data;
        end
    end

    // Oscillator controls and pin sharing
    assign osc_ctrl.fast_rc_run = fast_run;
    assign osc_ctrl.slow_rc_run = slow_rc_run;
    assign osc_ctrl.crystal_run = xt_run;
    assign osc_ctrl.crystal_low_power = !slow_crystal_quick_start_q;
    // Crystal counts as used whenever it is enabled
    wire xt_pins_used = slow_crystal_enable_q;
    assign crystal_pins_to_osc = xt_pins_used;
    assign crystal_pin_func = xt_pins_used ? 2'h0 : pin_func_q;
endmodule // system_clock_source_select

// ### tb/system_clock_source_select_properties.sv
`timescale 1ns/1ps
module system_clock_source_select_checker (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Clock control
    input wire logic cpu_halt,
    input wire sysclk_pkg::osc_ctrl_t osc_ctrl,
    input wire logic system_clock_en,
    input wire logic sub_clock_en,
    input wire logic timer_clock_en,
    input wire logic [6:0] fast_div_en,
    input wire logic crystal_pins_to_osc,
    input wire logic [1:0] crystal_pin_func
);
    import sysclk_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_halt_gates_sys: assert property (
        cpu_halt |-> !system_clock_en)
        else $error("system tick while halted");
    a_sys_pulse_single: assert property (
        system_clock_en |=> !system_clock_en)
        else $error("system tick longer than one cycle");
    a_sub_pulse_single: assert property (
        sub_clock_en |=> !sub_clock_en)
        else $error("sub tick longer than one cycle");
    a_timer_follows_sub: assert property (
        !cpu_halt |-> timer_clock_en == sub_clock_en)
        else $error("timer tick differs from sub tick");
    a_pins_free_func: assert property (
        crystal_pins_to_osc |-> crystal_pin_func == 2'h0)
        else $error("pin function active while crystal in use");
    a_div_nested: assert property (
        (fast_div_en[6:1] & ~fast_div_en[5:0]) == 6'h00)
        else $error("divided tick without faster tick");
    a_div_needs_fast: assert property (
        !osc_ctrl.fast_rc_run [*8] |-> fast_div_en == 7'h00)
        else $error("fast ticks while fast oscillator stopped");
    a_ready_access: assert property (
        pready == (psel && penable))
        else $error("ready outside access phase");
    a_err_in_access: assert property (
        pslverr |-> pready && $rose(penable))
        else $error("error response outside first access cycle");
endmodule // system_clock_source_select_checker

bind system_clock_source_select system_clock_source_select_checker
    system_clock_source_select_checker_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .cpu_halt(cpu_halt),
    .osc_ctrl(osc_ctrl), .system_clock_en(system_clock_en),
    .sub_clock_en(sub_clock_en), .timer_clock_en(timer_clock_en),
    .fast_div_en(fast_div_en), .crystal_pins_to_osc(crystal_pins_to_osc),
    .crystal_pin_func(crystal_pin_func));

// ### tb/system_clock_source_select_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("mismatch %s exp %0h got %0h", n, e, g); \
    end \
end
module system_clock_source_select_bench;
    import sysclk_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cpu_halt = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, system_clock_en, sub_clock_en;
    logic fast_rc_osc = 1'b0, slow_rc_osc = 1'b0, crystal_pin_in = 1'b0;
    logic timer_clock_en, crystal_pins_to_osc;
    osc_ctrl_t osc_ctrl;
    logic [6:0] fast_div_en;
    logic [1:0] crystal_pin_func;
    int bad_count = 0, tests_run = 0, cyc = 0, gap, ns;

    system_clock_source_select system_clock_source_select_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fast_rc_osc(fast_rc_osc),
        .slow_rc_osc(slow_rc_osc), .crystal_pin_in(crystal_pin_in),
        .cpu_halt(cpu_halt), .osc_ctrl(osc_ctrl),
        .system_clock_en(system_clock_en), .sub_clock_en(sub_clock_en),
        .timer_clock_en(timer_clock_en), .fast_div_en(fast_div_en),
        .crystal_pins_to_osc(crystal_pins_to_osc),
        .crystal_pin_func(crystal_pin_func));

    always #25 pclk = ~pclk;

    // Oscillators: fast period 4, slow RC 16, crystal 6; stopped when off
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        fast_rc_osc <= cyc[1] & osc_ctrl.fast_rc_run;
        slow_rc_osc <= cyc[3] & osc_ctrl.slow_rc_run;
        crystal_pin_in <= ((cyc % 6) < 3) & osc_ctrl.crystal_run;
        if (cyc == 50000) begin
            bad_count++;
            $display("timeout");
            tally_and_finish();
        end
    end

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Cycles between two system ticks
    task automatic sys_gap;
        @(posedge pclk iff system_clock_en === 1'b1);
        gap = 0;
        do begin
            @(posedge pclk);
            gap++;
        end while (system_clock_en !== 1'b1);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, ADDR_SCC, 0);
        `CHK("scc", 32'h0, rd)
        apb(0, ADDR_HIRCC, 0);
        `CHK("fast_en", 32'h1, rd & 32'h1)
        apb(0, ADDR_SLOW_CRYSTAL_CONTROL_REG, 0);
        `CHK("slow_crystal_control_reg", 32'h0, rd)
        apb(1, 12'h010, 32'hFF);
        `CHK("unmapped_err", 1'b1, err)
        apb(0, 12'h010, 0);
        `CHK("unmapped_rd", 32'h0, rd)
        $display("test reset done");
        for (int k = 0; k < 8; k++) begin
            apb(1, ADDR_SCC, k << 5);
            repeat (700) @(posedge pclk);
            sys_gap();
            `CHK("sys_gap", ((k == 7) ? 16 : (4 << k)), gap)
        end
        gap = 0;
        ns = 0;
        repeat (64) begin
            @(posedge pclk);
            gap += system_clock_en;
            ns += sub_clock_en;
        end
        `CHK("rc_sub_ticks", 4, ns)
        `CHK("sys_from_sub", 4, gap)
        gap = 0;
        while (fast_div_en[6] !== 1'b1 && gap < 300) begin
            @(posedge pclk);
            gap++;
        end
        `CHK("div64_in_slow", 1'b1, fast_div_en[6])
        $display("test divide done");
        apb(1, ADDR_HIRCC, 0);
        @(posedge pclk);
        `CHK("fast_stop", 1'b0, osc_ctrl.fast_rc_run)
        apb(1, ADDR_HIRCC, 1);
        apb(0, ADDR_HIRCC, 0);
        `CHK("flag_clear", 32'h1, rd)
        repeat (200) @(posedge pclk);
        apb(0, ADDR_HIRCC, 0);
        `CHK("flag_set", 32'h3, rd)
        cpu_halt <= 1'b1;
        repeat (50) @(posedge pclk);
        `CHK("halt_fast", 1'b0, osc_ctrl.fast_rc_run)
        `CHK("halt_slow", 1'b0, osc_ctrl.slow_rc_run)
        cpu_halt <= 1'b0;
        apb(1, ADDR_SCC, 32'hE3);
        cpu_halt <= 1'b1;
        gap = 0;
        ns = 0;
        repeat (60) begin
            @(posedge pclk);
            gap += timer_clock_en;
            ns += system_clock_en;
        end
        `CHK("timer_ticks", 1'b1, gap > 0)
        `CHK("sys_ticks", 0, ns)
        `CHK("keep_fast", 1'b1, osc_ctrl.fast_rc_run)
        `CHK("keep_slow", 1'b1, osc_ctrl.slow_rc_run)
        cpu_halt <= 1'b0;
        $display("test halt done");
        apb(1, ADDR_SCC, 0);
        apb(1, ADDR_PINS, 2);
        @(posedge pclk);
        `CHK("pin_func", 2'h2, crystal_pin_func)
        apb(1, ADDR_SLOW_CRYSTAL_CONTROL_REG, 5);
        @(posedge pclk);
        `CHK("pins_osc", 1'b1, crystal_pins_to_osc)
        `CHK("pin_func_off", 2'h0, crystal_pin_func)
        `CHK("quick_mode", 1'b0, osc_ctrl.crystal_low_power)
        apb(0, ADDR_SLOW_CRYSTAL_CONTROL_REG, 0);
        `CHK("xt_not_ready", 32'h5, rd)
        repeat (1700) @(posedge pclk);
        apb(0, ADDR_SLOW_CRYSTAL_CONTROL_REG, 0);
        `CHK("xt_ready", 32'h7, rd)
        apb(1, ADDR_SLOW_CRYSTAL_CONTROL_REG, 1);
        apb(0, ADDR_SLOW_CRYSTAL_CONTROL_REG, 0);
        `CHK("lp_running", 32'h3, rd)
        `CHK("lp_mode", 1'b1, osc_ctrl.crystal_low_power)
        apb(1, ADDR_SCC, 32'hE4);
        repeat (700) @(posedge pclk);
        sys_gap();
        `CHK("xt_sys_gap", 6, gap)
        apb(1, ADDR_SLOW_CRYSTAL_CONTROL_REG, 5);
        apb(0, ADDR_SLOW_CRYSTAL_CONTROL_REG, 0);
        `CHK("mode_locked", 32'h3, rd)
        apb(1, ADDR_SCC, 0);
        apb(1, ADDR_SLOW_CRYSTAL_CONTROL_REG, 0);
        apb(1, ADDR_SLOW_CRYSTAL_CONTROL_REG, 1);
        repeat (2000) @(posedge pclk);
        apb(0, ADDR_SLOW_CRYSTAL_CONTROL_REG, 0);
        `CHK("lp_slow_start", 32'h1, rd)
        repeat (11000) @(posedge pclk);
        apb(0, ADDR_SLOW_CRYSTAL_CONTROL_REG, 0);
        `CHK("lp_started", 32'h3, rd)
        $display("test crystal done");
        tally_and_finish();
    end
endmodule // system_clock_source_select_bench
